// file: hdl/pafm_pin_cell.sv
/*
 One pad driver: picks between peripheral and general-purpose drive and registers it.
 Assumes the caller resolves which peripheral owns the pin and any override.
*/
`timescale 1ns/1ps
`default_nettype none
module pafm_pin_cell (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_alt_active,
   input wire logic i_alt_drive,
   input wire logic i_alt_data,
   input wire logic i_gpio_drive,
   input wire logic i_gpio_data,
   input wire logic i_override,
   output logic o_pad_out,
   output logic o_pad_oe_n
);
   logic pad_out_ff;
   logic pad_oe_n_ff;
   logic nxt_pad_out;
   logic nxt_pad_oe_n;

   always_comb begin
      nxt_pad_out = i_gpio_data;
      nxt_pad_oe_n = ~i_gpio_drive;
      if (i_override) begin
         // Crystal owns the pad
         nxt_pad_out = pafm_pkg::PAD_OUT_RST;
         nxt_pad_oe_n = pafm_pkg::PAD_OE_N_RST;
      end else if (i_alt_active) begin
         // Peripheral sets direction
         nxt_pad_out = i_alt_data;
         nxt_pad_oe_n = ~i_alt_drive;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pad_out_ff <= pafm_pkg::PAD_OUT_RST;
         pad_oe_n_ff <= pafm_pkg::PAD_OE_N_RST;
      end else begin
         pad_out_ff <= nxt_pad_out;
         pad_oe_n_ff <= nxt_pad_oe_n;
      end
   end

   assign o_pad_out = pad_out_ff;
   assign o_pad_oe_n = pad_oe_n_ff;
endmodule
`default_nettype wire

// file: hdl/pafm_pkg.sv
/*
 Constants for the port alternate-function mux: pin positions, reset and idle values.
 Assumes nothing of its surroundings; imported by name only.
*/
package pafm_pkg;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 3;
   localparam int PAD_W = PORT_W * NUM_PORTS;
   // Port offsets inside the packed pad vector
   localparam int PORTA_BASE = 0;
   localparam int PORTB_BASE = 8;
   localparam int PORTC_BASE = 16;
   // Port A pin positions
   localparam int PA_T0 = 0;
   localparam int PA_TIMER_ZERO_OUTPUT = 1;
   localparam int PA_DE = 2;
   localparam int PA_CTS = 3;
   localparam int PA_RXD = 4;
   localparam int PA_TXD = 5;
   localparam int PA_T1 = 6;
   localparam int PA_TIMER_ONE_OUTPUT = 7;
   // Port B pin positions
   localparam int PB_ADC_INPUT_ZERO = 0;
   localparam int PB_ANA1 = 1;
   localparam int PB_ANA2 = 2;
   localparam int PB_CLK = 3;
   localparam int PB_ADC_INPUT_SEVEN = 4;
   localparam int PB_VREF = 5;
   // Port C pin positions
   localparam int PC_COMPARATOR_POSITIVE_INPUT = 0;
   localparam int PC_COMPARATOR_NEGATIVE_INPUT = 1;
   localparam int PC_ADC_INPUT_SIX = 2;
   localparam int PC_COMPARATOR_OUTPUT = 3;
   // Selection values for the two-way ports
   localparam logic SEL_LOW = 1'b0;
   localparam logic SEL_HIGH = 1'b1;
   // Reset and idle values
   localparam logic PAD_OUT_RST = 1'b0;
   localparam logic PAD_OE_N_RST = 1'b1;
   localparam logic RX_IDLE = 1'b1;
   localparam logic CTS_IDLE = 1'b1;
   localparam logic TIMER_IN_IDLE = 1'b0;
   localparam logic CLK_IN_IDLE = 1'b0;
   localparam logic [7:0] ADC_CONN_RST = 8'h00;
   localparam logic [2:0] AMP_CONN_RST = 3'h0;
   localparam logic [1:0] CMP_CONN_RST = 2'h0;
   localparam logic VREF_CONN_RST = 1'b0;
endpackage

// file: hdl/pafm_port_alt_function_mux.sv
/*
 Alternate-function mux for ports A, B and C: routes pads to GPIO or peripherals.
 Assumes software programs enables and selections; pad inputs are synchronous.
*/
// Overview of operation
// - Port A has no set selection; enable alone connects the single function.
// - Ports B, C use only first selection bit; second ignored; enable required.
// - Port A pins 0, 6 pick timer input or complement from timer mode.
// - Port A maps timer 0, UART enable, CTS, receive, transmit, timer 1.
// - Port B pins 0-2 with bit 1 give ADC inputs 0-2 and amplifier.
// - Port B pin 3: clock input or ADC 3; pin 4 ADC 7; pin 5 reference.
// - Port C pins 0, 1 with bit 1 give comparator positive, negative inputs.
// - Port C pin 2 with bit 1 gives ADC input 6, plus reference on 20-pin.
// - Reference on port B pin 5 for 28-pin, port C pin 2 for 20-pin.
// - Port C pin 3 with bit 0 drives comparator output.
// - Alternate mode gives pin direction to the peripheral.
// - Crystal enable overrides port A pins 0 and 1.
`timescale 1ns/1ps
`default_nettype none
module pafm_port_alt_function_mux (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_pkg_28pin,
   input wire logic i_crystal_enable,
   input wire logic [7:0] i_pa_alt_function_enable_sub,
   input wire logic [7:0] i_pb_alt_function_enable_sub,
   input wire logic [7:0] i_pc_alt_function_enable_sub,
   input wire logic [7:0] i_pb_function_set_select_one,
   input wire logic [7:0] i_pb_function_set_select_two,
   input wire logic [7:0] i_pc_function_set_select_one,
   input wire logic [7:0] i_pc_function_set_select_two,
   input wire logic [7:0] i_pa_gpio_out,
   input wire logic [7:0] i_pa_gpio_drive,
   input wire logic [7:0] i_pb_gpio_out,
   input wire logic [7:0] i_pb_gpio_drive,
   input wire logic [7:0] i_pc_gpio_out,
   input wire logic [7:0] i_pc_gpio_drive,
   input wire logic [7:0] i_pa_pad_in,
   input wire logic [7:0] i_pb_pad_in,
   input wire logic [7:0] i_pc_pad_in,
   input wire logic i_timer0_pin_is_output,
   input wire logic i_timer1_pin_is_output,
   input wire logic i_timer_zero_output,
   input wire logic i_timer_zero_output_compl,
   input wire logic i_timer_one_output,
   input wire logic i_timer_one_output_compl,
   input wire logic i_uart_driver_enable,
   input wire logic i_uart_transmit_data,
   input wire logic i_comparator_output,
   output logic [7:0] o_pa_pad_out,
   output logic [7:0] o_pa_pad_oe_n,
   output logic [7:0] o_pb_pad_out,
   output logic [7:0] o_pb_pad_oe_n,
   output logic [7:0] o_pc_pad_out,
   output logic [7:0] o_pc_pad_oe_n,
   output logic o_timer_zero_input,
   output logic o_timer_one_input,
   output logic o_uart_receive_data,
   output logic o_uart_clear_to_send,
   output logic o_external_clock_input,
   output logic o_external_clock_valid,
   output logic [7:0] o_adc_input_connect,
   output logic o_adc_vref_connect,
   output logic [2:0] o_amplifier_connect,
   output logic [1:0] o_comparator_connect
);
   localparam int W = pafm_pkg::PORT_W;

   // Function-set decode for two-way ports
   function automatic logic sel_on(input logic en, input logic sel, input logic want);
      sel_on = en && (sel == want);
   endfunction

   logic [W-1:0] a_en;
   logic [W-1:0] b_sel;
   logic [W-1:0] c_sel;
   logic xtal;
   logic b_adc_input_zero;
   logic b_ana1;
   logic b_ana2;
   logic b_clk;
   logic b_adc_input_three;
   logic b_adc_input_seven;
   logic b_vref;
   logic c_comparator_positive_input;
   logic c_comparator_negative_input;
   logic c_adc_input_six;
   logic c_comparator_output;
   logic [W-1:0] a_act;
   logic [W-1:0] a_drv;
   logic [W-1:0] a_dat;
   logic [W-1:0] b_act;
   logic [W-1:0] c_act;
   logic [W-1:0] c_drv;
   logic [W-1:0] c_dat;
   logic [pafm_pkg::PAD_W-1:0] alt_act;
   logic [pafm_pkg::PAD_W-1:0] alt_drv;
   logic [pafm_pkg::PAD_W-1:0] alt_dat;
   logic [pafm_pkg::PAD_W-1:0] gp_drv;
   logic [pafm_pkg::PAD_W-1:0] gp_dat;
   logic [pafm_pkg::PAD_W-1:0] ovr;
   logic [pafm_pkg::PAD_W-1:0] pad_out;
   logic [pafm_pkg::PAD_W-1:0] pad_oe_n;

   assign xtal = i_crystal_enable;
   // Port A: enable alone connects the function
   assign a_en = i_pa_alt_function_enable_sub;
   // Second set register deliberately unused
   assign b_sel = i_pb_function_set_select_one;
   assign c_sel = i_pc_function_set_select_one;

   // Port B decode
   assign b_adc_input_zero = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_ADC_INPUT_ZERO],
      b_sel[pafm_pkg::PB_ADC_INPUT_ZERO], pafm_pkg::SEL_HIGH);
   assign b_ana1 = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_ANA1],
      b_sel[pafm_pkg::PB_ANA1], pafm_pkg::SEL_HIGH);
   assign b_ana2 = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_ANA2],
      b_sel[pafm_pkg::PB_ANA2], pafm_pkg::SEL_HIGH);
   assign b_clk = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_CLK],
      b_sel[pafm_pkg::PB_CLK], pafm_pkg::SEL_LOW);
   assign b_adc_input_three = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_CLK],
      b_sel[pafm_pkg::PB_CLK], pafm_pkg::SEL_HIGH);
   assign b_adc_input_seven = sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_ADC_INPUT_SEVEN],
      b_sel[pafm_pkg::PB_ADC_INPUT_SEVEN], pafm_pkg::SEL_HIGH);
   assign b_vref = i_pkg_28pin && sel_on(i_pb_alt_function_enable_sub[pafm_pkg::PB_VREF],
      b_sel[pafm_pkg::PB_VREF], pafm_pkg::SEL_HIGH);

   // Port C decode
   assign c_comparator_positive_input = sel_on(i_pc_alt_function_enable_sub[pafm_pkg::PC_COMPARATOR_POSITIVE_INPUT],
      c_sel[pafm_pkg::PC_COMPARATOR_POSITIVE_INPUT], pafm_pkg::SEL_HIGH);
   assign c_comparator_negative_input = sel_on(i_pc_alt_function_enable_sub[pafm_pkg::PC_COMPARATOR_NEGATIVE_INPUT],
      c_sel[pafm_pkg::PC_COMPARATOR_NEGATIVE_INPUT], pafm_pkg::SEL_HIGH);
   assign c_adc_input_six = sel_on(i_pc_alt_function_enable_sub[pafm_pkg::PC_ADC_INPUT_SIX],
      c_sel[pafm_pkg::PC_ADC_INPUT_SIX], pafm_pkg::SEL_HIGH);
   assign c_comparator_output = sel_on(i_pc_alt_function_enable_sub[pafm_pkg::PC_COMPARATOR_OUTPUT],
      c_sel[pafm_pkg::PC_COMPARATOR_OUTPUT], pafm_pkg::SEL_LOW);

   // Pad ownership and drive per port
   always_comb begin
      a_act = a_en;
      a_act[pafm_pkg::PA_T0] = a_en[pafm_pkg::PA_T0] && !xtal;
      a_act[pafm_pkg::PA_TIMER_ZERO_OUTPUT] = a_en[pafm_pkg::PA_TIMER_ZERO_OUTPUT] && !xtal;
      a_drv = '0;
      a_dat = '0;
      // Timer pins 0 and 6 follow timer mode
      a_drv[pafm_pkg::PA_T0] = i_timer0_pin_is_output;
      a_dat[pafm_pkg::PA_T0] = i_timer_zero_output_compl;
      a_drv[pafm_pkg::PA_T1] = i_timer1_pin_is_output;
      a_dat[pafm_pkg::PA_T1] = i_timer_one_output_compl;
      a_drv[pafm_pkg::PA_TIMER_ZERO_OUTPUT] = 1'b1;
      a_dat[pafm_pkg::PA_TIMER_ZERO_OUTPUT] = i_timer_zero_output;
      a_drv[pafm_pkg::PA_DE] = 1'b1;
      a_dat[pafm_pkg::PA_DE] = i_uart_driver_enable;
      a_drv[pafm_pkg::PA_TXD] = 1'b1;
      a_dat[pafm_pkg::PA_TXD] = i_uart_transmit_data;
      a_drv[pafm_pkg::PA_TIMER_ONE_OUTPUT] = 1'b1;
      a_dat[pafm_pkg::PA_TIMER_ONE_OUTPUT] = i_timer_one_output;
      // Reserved port B/C choices stay GPIO
      b_act = '0;
      b_act[pafm_pkg::PB_ADC_INPUT_ZERO] = b_adc_input_zero;
      b_act[pafm_pkg::PB_ANA1] = b_ana1;
      b_act[pafm_pkg::PB_ANA2] = b_ana2;
      b_act[pafm_pkg::PB_CLK] = b_clk || b_adc_input_three;
      b_act[pafm_pkg::PB_ADC_INPUT_SEVEN] = b_adc_input_seven;
      b_act[pafm_pkg::PB_VREF] = b_vref;
      c_act = '0;
      c_act[pafm_pkg::PC_COMPARATOR_POSITIVE_INPUT] = c_comparator_positive_input;
      c_act[pafm_pkg::PC_COMPARATOR_NEGATIVE_INPUT] = c_comparator_negative_input;
      c_act[pafm_pkg::PC_ADC_INPUT_SIX] = c_adc_input_six;
      c_act[pafm_pkg::PC_COMPARATOR_OUTPUT] = c_comparator_output;
      c_drv = '0;
      c_dat = '0;
      c_drv[pafm_pkg::PC_COMPARATOR_OUTPUT] = 1'b1;
      c_dat[pafm_pkg::PC_COMPARATOR_OUTPUT] = i_comparator_output;
   end

   assign alt_act = {c_act, b_act, a_act};
   // Port B functions are analog or input only: no digital drive
   assign alt_drv = {c_drv, {W{1'b0}}, a_drv};
   assign alt_dat = {c_dat, {W{1'b0}}, a_dat};
   assign gp_drv = {i_pc_gpio_drive, i_pb_gpio_drive, i_pa_gpio_drive};
   assign gp_dat = {i_pc_gpio_out, i_pb_gpio_out, i_pa_gpio_out};

   always_comb begin
      ovr = '0;
      ovr[pafm_pkg::PORTA_BASE + pafm_pkg::PA_T0] = xtal;
      ovr[pafm_pkg::PORTA_BASE + pafm_pkg::PA_TIMER_ZERO_OUTPUT] = xtal;
   end

   genvar gi;
   generate
      for (gi = 0; gi < pafm_pkg::PAD_W; gi++) begin : g_pad
         pafm_pin_cell u_cell (
            .i_ref_clk(i_ref_clk),
            .i_rst_n(i_rst_n),
            .i_alt_active(alt_act[gi]),
            .i_alt_drive(alt_drv[gi]),
            .i_alt_data(alt_dat[gi]),
            .i_gpio_drive(gp_drv[gi]),
            .i_gpio_data(gp_dat[gi]),
            .i_override(ovr[gi]),
            .o_pad_out(pad_out[gi]),
            .o_pad_oe_n(pad_oe_n[gi])
         );
      end
   endgenerate

   assign o_pa_pad_out = pad_out[pafm_pkg::PORTA_BASE +: W];
   assign o_pb_pad_out = pad_out[pafm_pkg::PORTB_BASE +: W];
   assign o_pc_pad_out = pad_out[pafm_pkg::PORTC_BASE +: W];
   assign o_pa_pad_oe_n = pad_oe_n[pafm_pkg::PORTA_BASE +: W];
   assign o_pb_pad_oe_n = pad_oe_n[pafm_pkg::PORTB_BASE +: W];
   assign o_pc_pad_oe_n = pad_oe_n[pafm_pkg::PORTC_BASE +: W];

   // Peripheral-facing registers
   logic t0_in_ff, t1_in_ff, rx_ff, cts_ff, clk_ff, clk_vld_ff, vref_ff;
   logic [7:0] adc_ff;
   logic [2:0] amp_ff;
   logic [1:0] cmp_ff;
   logic nxt_t0_in, nxt_t1_in, nxt_rx, nxt_cts, nxt_clk, nxt_clk_vld, nxt_vref;
   logic [7:0] nxt_adc;
   logic [2:0] nxt_amp;
   logic [1:0] nxt_cmp;

   always_comb begin
      nxt_t0_in = pafm_pkg::TIMER_IN_IDLE;
      nxt_t1_in = pafm_pkg::TIMER_IN_IDLE;
      if (a_act[pafm_pkg::PA_T0] && !i_timer0_pin_is_output) begin
         nxt_t0_in = i_pa_pad_in[pafm_pkg::PA_T0];
      end
      if (a_act[pafm_pkg::PA_T1] && !i_timer1_pin_is_output) begin
         nxt_t1_in = i_pa_pad_in[pafm_pkg::PA_T1];
      end
      nxt_rx = a_act[pafm_pkg::PA_RXD] ? i_pa_pad_in[pafm_pkg::PA_RXD]
         : pafm_pkg::RX_IDLE;
      nxt_cts = a_act[pafm_pkg::PA_CTS] ? i_pa_pad_in[pafm_pkg::PA_CTS]
         : pafm_pkg::CTS_IDLE;
      nxt_clk = b_clk ? i_pb_pad_in[pafm_pkg::PB_CLK] : pafm_pkg::CLK_IN_IDLE;
      nxt_clk_vld = b_clk;
      nxt_adc = pafm_pkg::ADC_CONN_RST;
      nxt_adc[0] = b_adc_input_zero;
      nxt_adc[1] = b_ana1;
      nxt_adc[2] = b_ana2;
      nxt_adc[3] = b_adc_input_three;
      nxt_adc[4] = c_comparator_positive_input;
      nxt_adc[5] = c_comparator_negative_input;
      nxt_adc[6] = c_adc_input_six;
      nxt_adc[7] = b_adc_input_seven;
      nxt_vref = b_vref || (c_adc_input_six && !i_pkg_28pin);
      nxt_amp = {b_ana2, b_ana1, b_adc_input_zero};
      nxt_cmp = {c_comparator_negative_input, c_comparator_positive_input};
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         t0_in_ff <= pafm_pkg::TIMER_IN_IDLE;
         t1_in_ff <= pafm_pkg::TIMER_IN_IDLE;
         rx_ff <= pafm_pkg::RX_IDLE;
         cts_ff <= pafm_pkg::CTS_IDLE;
         clk_ff <= pafm_pkg::CLK_IN_IDLE;
         clk_vld_ff <= 1'b0;
         adc_ff <= pafm_pkg::ADC_CONN_RST;
         vref_ff <= pafm_pkg::VREF_CONN_RST;
         amp_ff <= pafm_pkg::AMP_CONN_RST;
         cmp_ff <= pafm_pkg::CMP_CONN_RST;
      end else begin
         t0_in_ff <= nxt_t0_in;
         t1_in_ff <= nxt_t1_in;
         rx_ff <= nxt_rx;
         cts_ff <= nxt_cts;
         clk_ff <= nxt_clk;
         clk_vld_ff <= nxt_clk_vld;
         adc_ff <= nxt_adc;
         vref_ff <= nxt_vref;
         amp_ff <= nxt_amp;
         cmp_ff <= nxt_cmp;
      end
   end

   assign o_timer_zero_input = t0_in_ff;
   assign o_timer_one_input = t1_in_ff;
   assign o_uart_receive_data = rx_ff;
   assign o_uart_clear_to_send = cts_ff;
   assign o_external_clock_input = clk_ff;
   assign o_external_clock_valid = clk_vld_ff;
   assign o_adc_input_connect = adc_ff;
   assign o_adc_vref_connect = vref_ff;
   assign o_amplifier_connect = amp_ff;
   assign o_comparator_connect = cmp_ff;
endmodule
`default_nettype wire

// file: sim/pafm_periph_model.sv
/*
 Peripheral side model: timers, UART and comparator outputs.
 Assumes the bench reads the values just before each rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pafm_periph_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   output logic [6:0] o_pattern
);
   logic [6:0] pat_ff;
   logic [6:0] nxt_pat;
   // Odd step so the low bit flips each cycle
   always_comb nxt_pat = i_rst_n ? pat_ff + 7'h2b : 7'h05;
   always_ff @(posedge i_clk) pat_ff <= nxt_pat;
   assign o_pattern = pat_ff;
endmodule
`default_nettype wire

// file: sim/pafm_sva.sv
/*
 Checker for the port alternate-function mux, bound to its top module.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pafm_sva (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_pkg_28pin,
   input wire logic i_crystal_enable,
   input wire logic [7:0] i_pa_alt_function_enable_sub,
   input wire logic [7:0] i_pb_alt_function_enable_sub,
   input wire logic [7:0] i_pc_alt_function_enable_sub,
   input wire logic [7:0] i_pb_function_set_select_one,
   input wire logic [7:0] i_pc_function_set_select_one,
   input wire logic [7:0] i_pb_gpio_drive,
   input wire logic [7:0] i_pb_pad_in,
   input wire logic i_timer0_pin_is_output,
   input wire logic i_timer_zero_output_compl,
   input wire logic i_timer_one_output,
   input wire logic i_comparator_output,
   input wire logic [7:0] o_pa_pad_out,
   input wire logic [7:0] o_pa_pad_oe_n,
   input wire logic [7:0] o_pb_pad_oe_n,
   input wire logic [7:0] o_pc_pad_out,
   input wire logic [7:0] o_pc_pad_oe_n,
   input wire logic o_external_clock_input,
   input wire logic o_external_clock_valid,
   input wire logic [7:0] o_adc_input_connect,
   input wire logic o_adc_vref_connect,
   input wire logic [1:0] o_comparator_connect
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   a_pa7_timer_drive: assert property (i_pa_alt_function_enable_sub[7] |=>
      !o_pa_pad_oe_n[7] && o_pa_pad_out[7] == $past(i_timer_one_output))
      else $error("pin A7 not driven by timer 1");
   a_pa0_compl_out: assert property (i_pa_alt_function_enable_sub[0] &&
      i_timer0_pin_is_output && !i_crystal_enable |=>
      !o_pa_pad_oe_n[0] && o_pa_pad_out[0] == $past(i_timer_zero_output_compl))
      else $error("pin A0 not driving timer complement");
   a_crystal_pins_free: assert property (i_crystal_enable |=> o_pa_pad_oe_n[1:0] == 2'b11)
      else $error("crystal pins still driven");
   a_clock_in_route: assert property (i_pb_alt_function_enable_sub[3] &&
      !i_pb_function_set_select_one[3] |=>
      o_external_clock_valid && o_external_clock_input == $past(i_pb_pad_in[3]))
      else $error("clock input not routed from B3");
   a_adc_low_pins: assert property (1'b1 |=> o_adc_input_connect[2:0] ==
      $past(i_pb_alt_function_enable_sub[2:0] & i_pb_function_set_select_one[2:0]))
      else $error("adc inputs 0 to 2 wrong");
   a_vref_by_pkg: assert property (1'b1 |=> o_adc_vref_connect == $past(
      (i_pb_alt_function_enable_sub[5] & i_pb_function_set_select_one[5] & i_pkg_28pin) |
      (i_pc_alt_function_enable_sub[2] & i_pc_function_set_select_one[2] & !i_pkg_28pin)))
      else $error("reference connect wrong");
   a_cmp_inputs: assert property (1'b1 |=> o_comparator_connect == $past(
      i_pc_alt_function_enable_sub[1:0] & i_pc_function_set_select_one[1:0]))
      else $error("comparator inputs wrong");
   a_comparator_output_drive: assert property (i_pc_alt_function_enable_sub[3] &&
      !i_pc_function_set_select_one[3] |=>
      !o_pc_pad_oe_n[3] && o_pc_pad_out[3] == $past(i_comparator_output))
      else $error("comparator output not on C3");
   a_pb_reserved_gpio: assert property (1'b1 |=>
      o_pb_pad_oe_n[7:6] == ~$past(i_pb_gpio_drive[7:6]))
      else $error("B6 B7 not plain GPIO");
   c_clock_used: cover property (o_external_clock_valid);
   c_vref_used: cover property (o_adc_vref_connect);
   c_crystal_on: cover property (i_crystal_enable);
endmodule
bind pafm_port_alt_function_mux pafm_sva u_sva (.*);
`default_nettype wire

// file: sim/tb.sv
/*
 Self-checking bench for the port alternate-function mux.
 Assumes one-cycle latency from inputs to registered outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
   logic clk, rst_n, pkg, xtal, t0m, t1m, t0i, t1i, rxd, cts, ckin, ckv, vref;
   logic [7:0] pa_en, pb_en, pc_en, pb_s1, pb_s2, pc_s1, pc_s2, pa_go, pa_gd, pb_go, pb_gd;
   logic [7:0] pc_go, pc_gd, pa_in, pb_in, pc_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
   logic [7:0] adc;
   logic [6:0] pat, snap;
   logic [2:0] amp;
   logic [1:0] cmp;
   int err_count, n_compared, cycles;
   pafm_periph_model u_periph (.i_clk(clk), .i_rst_n(rst_n), .o_pattern(pat));
   pafm_port_alt_function_mux DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_pkg_28pin(pkg),
      .i_crystal_enable(xtal), .i_pa_alt_function_enable_sub(pa_en),
      .i_pb_alt_function_enable_sub(pb_en), .i_pc_alt_function_enable_sub(pc_en),
      .i_pb_function_set_select_one(pb_s1), .i_pb_function_set_select_two(pb_s2),
      .i_pc_function_set_select_one(pc_s1), .i_pc_function_set_select_two(pc_s2),
      .i_pa_gpio_out(pa_go), .i_pa_gpio_drive(pa_gd), .i_pb_gpio_out(pb_go),
      .i_pb_gpio_drive(pb_gd), .i_pc_gpio_out(pc_go), .i_pc_gpio_drive(pc_gd),
      .i_pa_pad_in(pa_in), .i_pb_pad_in(pb_in), .i_pc_pad_in(pc_in),
      .i_timer0_pin_is_output(t0m), .i_timer1_pin_is_output(t1m),
      .i_timer_zero_output(pat[6]), .i_timer_zero_output_compl(pat[5]),
      .i_timer_one_output(pat[4]), .i_timer_one_output_compl(pat[3]),
      .i_uart_driver_enable(pat[2]), .i_uart_transmit_data(pat[1]),
      .i_comparator_output(pat[0]), .o_pa_pad_out(pa_out), .o_pa_pad_oe_n(pa_oe),
      .o_pb_pad_out(pb_out), .o_pb_pad_oe_n(pb_oe), .o_pc_pad_out(pc_out),
      .o_pc_pad_oe_n(pc_oe), .o_timer_zero_input(t0i), .o_timer_one_input(t1i),
      .o_uart_receive_data(rxd), .o_uart_clear_to_send(cts), .o_external_clock_input(ckin),
      .o_external_clock_valid(ckv), .o_adc_input_connect(adc), .o_adc_vref_connect(vref),
      .o_amplifier_connect(amp), .o_comparator_connect(cmp));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tick;
      @(negedge clk);
      snap = pat;
      @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_reset;
      `CHK("oe_n", 24'hffffff, {pc_oe, pb_oe, pa_oe})
      `CHK("pad out", 24'h000000, {pc_out, pb_out, pa_out})
      `CHK("idle ins", 6'h0c, {t0i, t1i, rxd, cts, ckin, ckv})
      `CHK("connects", 14'h0000, {adc, vref, amp, cmp})
      $display("test reset done");
   endtask
   task automatic t_port_a;
      xtal = 1'b0;
      pa_en = 8'hff;
      pa_gd = 8'hff;
      pa_in = 8'h41;
      for (int m = 0; m < 4; m++) begin
         t0m = m[1];
         t1m = m[1];
         tick();
         `CHK("pa oe_n", ~(8'ha6 | {1'b0, m[1], 5'h00, m[1]}), pa_oe)
         `CHK("pa t0 de", {snap[2], snap[6]}, pa_out[2:1])
         `CHK("pa t1 txd", {snap[4], snap[1]}, {pa_out[7], pa_out[5]})
         if (m[1]) `CHK("pa compl", {snap[3], snap[5]}, {pa_out[6], pa_out[0]})
         `CHK("pa timer in", m[1] ? 2'b00 : 2'b11, {t0i, t1i})
         `CHK("pa uart in", 2'b00, {rxd, cts})
      end
      $display("test port a done");
   endtask
   task automatic t_crystal;
      pa_en = 8'h03;
      pa_gd = 8'h0f;
      pa_go = 8'h5a;
      pa_in = 8'h01;
      t0m = 1'b0;
      t1m = 1'b0;
      xtal = 1'b1;
      tick();
      `CHK("xtal oe_n", 8'hf3, pa_oe)
      `CHK("pa gpio out", 2'b10, pa_out[3:2])
      `CHK("xtal ins", 3'b011, {t0i, rxd, cts})
      xtal = 1'b0;
      tick();
      `CHK("free oe_n", 8'hf1, pa_oe)
      `CHK("free t0", {1'b1, snap[6]}, {t0i, pa_out[1]})
      $display("test crystal done");
   endtask
   task automatic t_port_b;
      pkg = 1'b1;
      pb_en = 8'hff;
      pb_s1 = 8'h37;
      pb_s2 = 8'hff;
      pb_gd = 8'hff;
      pb_go = 8'h80;
      pb_in = 8'h08;
      tick();
      `CHK("pb adc", 8'h87, adc)
      `CHK("pb amp", 3'h7, amp)
      `CHK("pb vref", 1'b1, vref)
      `CHK("clock in", 2'b11, {ckin, ckv})
      `CHK("pb oe_n", 8'h3f, pb_oe)
      `CHK("pb gpio", 2'b10, pb_out[7:6])
      pkg = 1'b0;
      pb_s1 = 8'h28;
      pb_s2 = 8'h00;
      pb_go = 8'h55;
      tick();
      `CHK("pb adc_input_three", 8'h08, adc)
      `CHK("pb none", 6'h00, {vref, amp, ckin, ckv})
      `CHK("pb rsv oe_n", 8'h08, pb_oe & 8'hdf)
      `CHK("pb rsv out", 8'h55, pb_out & 8'hd7)
      pkg = 1'b1;
      pb_en = 8'h00;
      pb_s1 = 8'hff;
      tick();
      `CHK("pb off", 10'h000, {adc, vref, ckv})
      `CHK("pb off oe_n", 8'h00, pb_oe)
      $display("test port b done");
   endtask
   task automatic t_port_c;
      pkg = 1'b0;
      pc_en = 8'hff;
      pc_s1 = 8'h07;
      pc_s2 = 8'hf8;
      pc_gd = 8'hff;
      pc_go = 8'ha5;
      tick();
      `CHK("pc cmp", 2'b11, cmp)
      `CHK("pc adc", 8'h70, adc)
      `CHK("pc vref", 1'b1, vref)
      `CHK("pc oe_n", 8'h07, pc_oe)
      `CHK("pc out", {4'ha, snap[0]}, {pc_out[7:4], pc_out[3]})
      pkg = 1'b1;
      pc_s1 = 8'h08;
      tick();
      `CHK("pc rsv", 11'h000, {adc, vref, cmp})
      `CHK("pc rsv pads", 16'h00a5, {pc_oe, pc_out})
      pc_s1 = 8'h04;
      tick();
      `CHK("pc adc_input_six", 9'h080, {adc, vref})
      `CHK("pc comparator_output back", {8'h04, snap[0]}, {pc_oe, pc_out[3]})
      $display("test port c done");
   endtask
   task automatic t_mid_reset;
      rst_n = 1'b0;
      tick();
      t_reset();
      rst_n = 1'b1;
      tick();
      `CHK("after reset", {8'h40, 8'h04}, {adc, pc_oe})
      $display("test mid reset done");
   endtask
   localparam int MAX_CYC = 400;
   always @(posedge clk) begin
      cycles++;
      if (cycles == MAX_CYC) begin
         err_count++;
         $display("timeout after %0d cycles", cycles);
         summarize();
      end
   end
   initial begin
      rst_n = 1'b0;
      pkg = 1'b1;
      xtal = 1'b0;
      t0m = 1'b0;
      t1m = 1'b0;
      {pa_en, pb_en, pc_en, pb_s1, pb_s2, pc_s1, pc_s2} = 56'h0;
      {pa_go, pa_gd, pb_go, pb_gd, pc_go, pc_gd, pa_in, pb_in, pc_in} = 72'h0;
      repeat (8) tick();
      t_reset();
      rst_n = 1'b1;
      t_port_a();
      t_crystal();
      t_port_b();
      t_port_c();
      t_mid_reset();
      summarize();
   end
endmodule
